// ===== design/sclc_defines.svh
// Register offsets, field positions and reset values of the line and clock control
`ifndef SCLC_DEFINES_SVH
`define SCLC_DEFINES_SVH
`define SCLC_ADDR_TRMC      2'h0
`define SCLC_ADDR_CMC       2'h1
`define SCLC_ADDR_STAT      2'h2
`define SCLC_ADDR_MODE      2'h3
`define SCLC_TRMC_RESET     8'h00
`define SCLC_CMC_RESET      8'h08
`define SCLC_B_PRESET       7
`define SCLC_B_ENC_HI       6
`define SCLC_B_ENC_LO       5
`define SCLC_B_GAOP         4
`define SCLC_B_MARKIDLE     3
`define SCLC_B_ABORTUR      2
`define SCLC_B_LOOP         1
`define SCLC_B_SHORTSYNC    0
`define SCLC_B_XTAL         7
`define SCLC_B_RXC_HI       6
`define SCLC_B_RXC_LO       5
`define SCLC_B_TXC_HI       4
`define SCLC_B_TXC_LO       3
`define SCLC_B_CLKDIR       2
`define SCLC_SDLC_RESIDUE   16'h1d0f
`define SCLC_CRC_ONES       16'hffff
`define SCLC_CRC_ZEROS      16'h0000
`define SCLC_CLOSE_BITS     5'h10
`define SCLC_XTAL_SETTLE_MS 20
`endif

// ===== design/sclc_pkg.sv
// Types of the line and clock control block
package sclc_pkg;
    typedef enum logic [1:0]
    {
        ENC_NRZ  = 2'h0,
        ENC_NRZI = 2'h1,
        ENC_FM1  = 2'h2,
        ENC_FM0  = 2'h3
    } sclc_enc_t;
    typedef enum logic [1:0]
    {
        CLK_FIRST = 2'h0,
        CLK_BIDIR = 2'h1,
        CLK_BAUD  = 2'h2,
        CLK_DPLL  = 2'h3
    } sclc_clksrc_t;
    typedef enum logic [1:0]
    {
        PROTO_ASYNC = 2'h0,
        PROTO_MONO  = 2'h1,
        PROTO_BI    = 2'h2,
        PROTO_SDLC  = 2'h3
    } sclc_proto_t;
    typedef enum logic [1:0]
    {
        LOOP_OFF     = 2'h0,
        LOOP_GATED   = 2'h1,
        LOOP_ONDELAY = 2'h3,
        LOOP_ACTIVE  = 2'h2
    } sclc_loop_t;
endpackage

// ===== design/sclc_clock_mux.sv
// Four-way clock source selector
`timescale 1ns/1ps
`default_nettype none
module sclc_clock_mux
(
    // Select
    input  wire logic [1:0] sel,
    // Sources
    input  wire logic       firstClk,
    input  wire logic       bidirClk,
    input  wire logic       baudClk,
    input  wire logic       dpllClk,
    // Result
    output logic            clkOut
);
    wire logic [3:0] srcVec;
    assign srcVec = {dpllClk, baudClk, bidirClk, firstClk};
    assign clkOut = srcVec[sel];
endmodule
`default_nettype wire

// ===== design/sclc_line_clock_ctrl.sv
// Line coding, loop and clock source control of one serial channel
//
// Decided for this implementation: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "sclc_defines.svh"
module sclc_line_clock_ctrl
(
    // Clock and resets
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        chanReset,
    // Register port
    input  wire logic [1:0]  addr,
    input  wire logic [7:0]  wrData,
    input  wire logic        wrStb,
    input  wire logic        rdStb,
    output logic      [7:0]  rdData,
    // Protocol context
    input  wire sclc_pkg::sclc_proto_t proto,
    input  wire logic        breakProg,
    // Link events from shifter and receiver
    input  wire logic        eopSeen,
    input  wire logic        flagSeen,
    input  wire logic        syncSeen,
    input  wire logic        charBoundary,
    input  wire logic        flagLeaving,
    input  wire logic        txUnderrun,
    input  wire logic        closeBitTick,
    input  wire logic [15:0] crcResidue,
    input  wire logic        rxFrameEnd,
    // Line pins
    input  wire logic        rxLine,
    input  wire logic        txShift,
    output logic             txLine,
    // Clock sources
    input  wire logic        firstClkPin,
    input  wire logic        bidirClkIn,
    input  wire logic        baudClk,
    input  wire logic        dpllRxClk,
    input  wire logic        dpllTxClkLag,
    input  wire logic        xtalOsc,
    input  wire logic        bidirSelSig,
    // Clock outputs
    output logic             rxClk,
    output logic             txClk,
    output logic             bidirClkOut,
    output logic             bidirClkOe,
    output logic             xtalEnable,
    output logic             syncInternal,
    // Line control outputs
    output logic      [15:0] crcPreset,
    output logic             crcInvert,
    output logic             crcGood,
    output sclc_pkg::sclc_enc_t encoding,
    output logic             idleOnes,
    output logic             sendAbortFlag,
    output logic             sendCrc,
    output logic             txActive,
    output logic             oneBitDelay,
    output logic             shortSync,
    output logic             bisyncRx12,
    output logic             underrunEom,
    output logic             extStatusIrq,
    output logic             txEmptyIrq
);
    logic [7:0] trmc_reg;
    logic [7:0] cmc_reg;
    sclc_pkg::sclc_loop_t loop_reg;
    sclc_pkg::sclc_loop_t loop_next;
    logic       txDone_reg;
    logic       flagAfter_reg;
    logic       closing_reg;
    logic [4:0] closeCnt_reg;
    logic       rxDelay_reg;
    logic       rxClkMux;
    logic       txClkMux;
    wire logic isSdlc;
    wire logic isAsync;
    wire logic isSyncNs;
    wire logic gaop;
    wire logic loopBit;
    wire logic markIdle;
    wire logic abortUr;
    wire logic bidirUsed;
    wire logic wrTrmc;
    wire logic wrCmc;
    wire logic fmMode;
    wire logic pollOk;
    wire logic onLoop;
    wire logic [1:0] rxSel;
    wire logic [1:0] txSel;
    wire logic [7:0] statWord;
    wire logic [7:0] rdMux;
    assign isSdlc   = (proto == sclc_pkg::PROTO_SDLC);
    assign isAsync  = (proto == sclc_pkg::PROTO_ASYNC);
    assign isSyncNs = !isSdlc && !isAsync;
    assign gaop     = trmc_reg[`SCLC_B_GAOP];
    assign loopBit  = trmc_reg[`SCLC_B_LOOP];
    assign markIdle = trmc_reg[`SCLC_B_MARKIDLE];
    assign abortUr  = trmc_reg[`SCLC_B_ABORTUR];
    assign wrTrmc   = wrStb && (addr == `SCLC_ADDR_TRMC);
    assign wrCmc    = wrStb && (addr == `SCLC_ADDR_CMC);
    assign rxSel    = cmc_reg[`SCLC_B_RXC_HI:`SCLC_B_RXC_LO];
    assign txSel    = cmc_reg[`SCLC_B_TXC_HI:`SCLC_B_TXC_LO];
    assign fmMode   = trmc_reg[`SCLC_B_ENC_HI];
    assign onLoop   = (loop_reg == sclc_pkg::LOOP_ONDELAY)
                   || (loop_reg == sclc_pkg::LOOP_ACTIVE);
    // Poll accepted only once a flag followed the last transmission
    assign pollOk   = eopSeen && gaop && (!txDone_reg || flagAfter_reg);
    assign bidirUsed = (rxSel == sclc_pkg::CLK_BIDIR)
                    || (txSel == sclc_pkg::CLK_BIDIR);
    // Control registers; channel reset spares the hardware-only fields
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            trmc_reg <= `SCLC_TRMC_RESET;
            cmc_reg  <= `SCLC_CMC_RESET;
        end
        else if (chanReset)
            trmc_reg <= trmc_reg & 8'h60;
        else
        begin
            if (wrTrmc)
                trmc_reg <= wrData;
            if (wrCmc)
                cmc_reg <= wrData;
        end
    end
    // SDLC loop state
    always_comb
    begin
        loop_next = loop_reg;
        unique case (loop_reg)
            sclc_pkg::LOOP_OFF:
                if (loopBit && isSdlc)
                    loop_next = sclc_pkg::LOOP_GATED;
            sclc_pkg::LOOP_GATED:
                if (!loopBit)
                    loop_next = sclc_pkg::LOOP_OFF;
                else if (eopSeen && gaop)
                    loop_next = sclc_pkg::LOOP_ONDELAY;
            sclc_pkg::LOOP_ONDELAY:
                if (eopSeen && !loopBit)
                    loop_next = sclc_pkg::LOOP_OFF;
                else if (pollOk)
                    loop_next = sclc_pkg::LOOP_ACTIVE;
            sclc_pkg::LOOP_ACTIVE:
                if (flagLeaving && !gaop)
                    loop_next = sclc_pkg::LOOP_ONDELAY;
        endcase
    end
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            loop_reg      <= sclc_pkg::LOOP_OFF;
            txDone_reg    <= 1'b0;
            flagAfter_reg <= 1'b0;
        end
        else if (chanReset)
        begin
            loop_reg      <= sclc_pkg::LOOP_OFF;
            txDone_reg    <= 1'b0;
            flagAfter_reg <= 1'b0;
        end
        else
        begin
            loop_reg <= loop_next;
            if (loop_reg == sclc_pkg::LOOP_ACTIVE
                && loop_next == sclc_pkg::LOOP_ONDELAY)
            begin
                txDone_reg    <= 1'b1;
                flagAfter_reg <= 1'b0;
            end
            else if (loop_next == sclc_pkg::LOOP_ACTIVE)
                txDone_reg <= 1'b0;
            else if (flagSeen && txDone_reg)
                flagAfter_reg <= 1'b1;
        end
    end
    // Underrun closing sequence of sixteen bit times
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            closing_reg  <= 1'b0;
            closeCnt_reg <= 5'h00;
        end
        else if (chanReset || (txUnderrun && isSdlc && !closing_reg))
        begin
            closing_reg  <= !chanReset;
            closeCnt_reg <= 5'h00;
        end
        else if (closing_reg && closeBitTick)
        begin
            if (closeCnt_reg == `SCLC_CLOSE_BITS - 5'h01)
                closing_reg <= 1'b0;
            closeCnt_reg <= closeCnt_reg + 5'h01;
        end
    end
    // Sync-mode transmitter enable and one-bit delay path
    logic syncTxEn_reg;
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            syncTxEn_reg <= 1'b0;
            rxDelay_reg  <= 1'b1;
        end
        else
        begin
            rxDelay_reg <= rxLine;
            if (chanReset || !loopBit || !isSyncNs)
                syncTxEn_reg <= 1'b0;
            else if (syncSeen && gaop && charBoundary)
                syncTxEn_reg <= 1'b1;
        end
    end
    // Clock source multiplexers
    sclc_clock_mux uRxMux
    (
        .sel      (rxSel),
        .firstClk (cmc_reg[`SCLC_B_XTAL] ? xtalOsc : firstClkPin),
        .bidirClk (bidirClkIn),
        .baudClk  (baudClk),
        .dpllClk  (dpllRxClk),
        .clkOut   (rxClkMux)
    );
    sclc_clock_mux uTxMux
    (
        .sel      (txSel),
        .firstClk (cmc_reg[`SCLC_B_XTAL] ? xtalOsc : firstClkPin),
        .bidirClk (bidirClkIn),
        .baudClk  (baudClk),
        .dpllClk  (fmMode ? dpllTxClkLag : dpllRxClk),
        .clkOut   (txClkMux)
    );
    // Line output selection
    logic txLineSel;
    always_comb
    begin
        txLineSel = txShift;
        if (isSdlc && loop_reg == sclc_pkg::LOOP_GATED)
            txLineSel = rxLine;
        else if (isSdlc && loop_reg == sclc_pkg::LOOP_ONDELAY)
            txLineSel = rxDelay_reg;
        else if (isSyncNs && loopBit && !syncTxEn_reg)
            txLineSel = !breakProg;
    end
    // Read side shows block state
    assign statWord = {2'h0, closing_reg, txDone_reg, flagAfter_reg,
                       syncTxEn_reg, loop_reg};
    assign rdMux = (addr == `SCLC_ADDR_TRMC) ? trmc_reg :
                   (addr == `SCLC_ADDR_CMC)  ? cmc_reg  :
                   (addr == `SCLC_ADDR_STAT) ? statWord : 8'h00;
    // Registered outputs
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rdData        <= 8'h00;
            txLine        <= 1'b1;
            rxClk         <= 1'b0;
            txClk         <= 1'b0;
            bidirClkOut   <= 1'b0;
            bidirClkOe    <= 1'b0;
            xtalEnable    <= 1'b0;
            syncInternal  <= 1'b0;
            crcPreset     <= `SCLC_CRC_ZEROS;
            crcInvert     <= 1'b0;
            crcGood       <= 1'b0;
            encoding      <= sclc_pkg::ENC_NRZ;
            idleOnes      <= 1'b0;
            sendAbortFlag <= 1'b0;
            sendCrc       <= 1'b0;
            txActive      <= 1'b0;
            oneBitDelay   <= 1'b0;
            shortSync     <= 1'b0;
            bisyncRx12    <= 1'b0;
            underrunEom   <= 1'b0;
            extStatusIrq  <= 1'b0;
            txEmptyIrq    <= 1'b0;
        end
        else
        begin
            rdData <= rdStb ? rdMux : 8'h00;
            txLine <= txLineSel;
            rxClk  <= rxClkMux;
            txClk  <= txClkMux;
            bidirClkOut <= bidirSelSig;
            bidirClkOe  <= cmc_reg[`SCLC_B_CLKDIR] && !bidirUsed;
            xtalEnable  <= cmc_reg[`SCLC_B_XTAL];
            syncInternal <= 1'b0;
            crcPreset <= (!isAsync && trmc_reg[`SCLC_B_PRESET])
                         ? `SCLC_CRC_ONES : `SCLC_CRC_ZEROS;
            crcInvert <= isSdlc;
            crcGood   <= isSdlc && rxFrameEnd
                         && (crcResidue == `SCLC_SDLC_RESIDUE);
            encoding  <= sclc_pkg::sclc_enc_t'(
                         trmc_reg[`SCLC_B_ENC_HI:`SCLC_B_ENC_LO]);
            // Loop bit masks idle and underrun choices while it is set
            idleOnes  <= isSdlc && !loopBit && markIdle;
            sendAbortFlag <= closing_reg && !loopBit && abortUr;
            sendCrc   <= closing_reg && (loopBit || !abortUr);
            if (closing_reg && !loopBit && abortUr && markIdle)
                idleOnes <= 1'b1;
            txActive  <= (loop_reg == sclc_pkg::LOOP_ACTIVE)
                         || syncTxEn_reg;
            oneBitDelay <= (loop_reg == sclc_pkg::LOOP_ONDELAY);
            shortSync <= trmc_reg[`SCLC_B_SHORTSYNC]
                         && (proto == sclc_pkg::PROTO_MONO);
            bisyncRx12 <= trmc_reg[`SCLC_B_SHORTSYNC]
                          && (proto == sclc_pkg::PROTO_BI);
            extStatusIrq <= txUnderrun && isSdlc && !closing_reg;
            txEmptyIrq <= closing_reg && closeBitTick
                          && closeCnt_reg == `SCLC_CLOSE_BITS - 5'h01;
            underrunEom <= !chanReset && ((txUnderrun && isSdlc
                           && !closing_reg) || (underrunEom && !wrTrmc));
        end
    end
    default clocking astClk @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence urStart;
        txUnderrun && isSdlc && !closing_reg && !chanReset;
    endsequence
    AST_BIDIR_OE: assert property (bidirUsed |=> !bidirClkOe)
        else $error("bidir pin driven while used as clock");
    AST_RESIDUE: assert property (rxFrameEnd && isSdlc
        && crcResidue == `SCLC_SDLC_RESIDUE |=> crcGood)
        else $error("good SDLC residue not flagged");
    AST_UR_START: assert property (urStart |=> extStatusIrq
        && underrunEom && closing_reg) else $error("underrun start missed");
    AST_CLOSE_END: assert property (closing_reg && closeBitTick
        && closeCnt_reg == `SCLC_CLOSE_BITS - 5'h01 |=> txEmptyIrq
        && !closing_reg) else $error("closing end missed");
    AST_LOOP_GATED: assert property (isSdlc
        && loop_reg == sclc_pkg::LOOP_GATED |=> txLine == $past(rxLine))
        else $error("gated loop does not pass line through");
    AST_ONLOOP_HOLD: assert property (onLoop && !loopBit
        && !eopSeen && !chanReset |=> onLoop) else $error("off loop early");
endmodule
`default_nettype wire

// ===== bench/sclc_line_partner.sv
// Serial line partner: link events, line levels and clock sources
`timescale 1ns/1ps
`default_nettype none
module sclc_line_partner
(
    // Clock
    input  wire logic        clk,
    // Link events
    output logic             eopSeen,
    output logic             flagSeen,
    output logic             syncSeen,
    output logic             charBoundary,
    output logic             flagLeaving,
    output logic             txUnderrun,
    output logic             closeBitTick,
    output logic             rxFrameEnd,
    output logic      [15:0] crcResidue,
    // Line
    output logic             rxLine,
    output logic             txShift,
    // Clock sources and bidirectional pin
    output logic             firstClkPin,
    output logic             bidirClkIn,
    output logic             baudClk,
    output logic             dpllRxClk,
    output logic             dpllTxClkLag,
    output logic             xtalOsc,
    output logic             bidirSelSig,
    input  wire logic        bidirClkOut,
    input  wire logic        bidirClkOe
);
    logic [7:0]  evReg   = 8'h00;
    logic [6:0]  srcReg  = 7'h00;
    logic [1:0]  lineReg = 2'h3;
    logic [15:0] resReg  = 16'h0000;
    assign {rxFrameEnd, closeBitTick, txUnderrun, flagLeaving,
            charBoundary, syncSeen, flagSeen, eopSeen} = evReg;
    assign {bidirSelSig, xtalOsc, dpllTxClkLag, dpllRxClk, baudClk}
           = srcReg[6:2];
    assign firstClkPin = srcReg[0];
    assign {txShift, rxLine} = lineReg;
    assign crcResidue = resReg;
    // Wire level: our driver gives way while the block drives the pin
    assign bidirClkIn = bidirClkOe ? bidirClkOut : srcReg[1];
    task automatic pulse(input int n, input int m = -1);
        @(posedge clk);
        evReg <= (8'h01 << n) | ((m >= 0) ? (8'h01 << m) : 8'h00);
        @(posedge clk);
        evReg <= 8'h00;
    endtask
    task automatic setSrc(input logic [6:0] v);
        @(posedge clk);
        srcReg <= v;
    endtask
    task automatic setLine(input logic [1:0] v);
        @(posedge clk);
        lineReg <= v;
    endtask
    task automatic setRes(input logic [15:0] v);
        @(posedge clk);
        resReg <= v;
    endtask
endmodule
`default_nettype wire

// ===== bench/tb_top.sv
// Self-checking bench of the line and clock control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam int LIMIT = 20000;
    logic        clk, rst_b, chanReset, wrStb, rdStb, breakProg, rdPend;
    logic        eopSeen, flagSeen, syncSeen, charBoundary, flagLeaving;
    logic        txUnderrun, closeBitTick, rxFrameEnd, rxLine, txShift;
    logic        firstClkPin, bidirClkIn, baudClk, dpllRxClk, dpllTxClkLag;
    logic        xtalOsc, bidirSelSig, txLine, rxClk, txClk, bidirClkOut;
    logic        bidirClkOe, xtalEnable, syncInternal, crcInvert, crcGood;
    logic        idleOnes, sendAbortFlag, sendCrc, txActive, oneBitDelay;
    logic        shortSync, bisyncRx12, underrunEom, extStatusIrq, txEmptyIrq;
    logic [1:0]  addr;
    logic [7:0]  wrData, rdData, cmc;
    logic [6:0]  src;
    logic [15:0] crcResidue, crcPreset, qv;
    logic [15:0] rdQ[$];
    sclc_pkg::sclc_proto_t proto;
    sclc_pkg::sclc_enc_t   encoding;
    int          mismatches, checks_done, cycles, nExt, nEmpty, nGood;
    sclc_line_clock_ctrl i_dut (.*);
    sclc_line_partner    i_line (.*);
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic checkVal(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask
    task automatic checkRead(input logic [7:0] got, input logic [15:0] q);
        checkVal({8'h00, got & q[15:8]}, {8'h00, q[7:0]});
    endtask
    // Cycle counter, read-back monitor and pulse counters
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == LIMIT)
        begin
            mismatches++;
            stop_test();
        end
        if (rdPend)
        begin
            qv = rdQ.pop_front();
            checkRead(rdData, qv);
        end
        rdPend = rdStb;
        nExt += int'(extStatusIrq === 1'b1);
        nEmpty += int'(txEmptyIrq === 1'b1);
        nGood += int'(crcGood === 1'b1);
    end
    task automatic regWrite(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wrData <= d;
        wrStb <= 1'b1;
        @(posedge clk);
        wrStb <= 1'b0;
    endtask
    task automatic regRead(input logic [1:0] a, input logic [7:0] e,
                           input logic [7:0] m);
        @(posedge clk);
        addr <= a;
        rdStb <= 1'b1;
        rdQ.push_back({m, e});
        @(posedge clk);
        rdStb <= 1'b0;
    endtask
    task automatic settle();
        repeat (3) @(posedge clk);
        #1;
    endtask
    task automatic setProto(input sclc_pkg::sclc_proto_t p);
        @(posedge clk);
        proto <= p;
    endtask
    function automatic logic pick(input logic [1:0] s, input logic x,
                                  input logic lag);
        case (s)
            2'h0: pick = x ? src[5] : src[0];
            2'h1: pick = src[1];
            2'h2: pick = src[2];
            default: pick = lag ? src[4] : src[3];
        endcase
    endfunction
    initial
    begin
        void'($urandom(32'hd951));
        {rst_b, chanReset, wrStb, rdStb, breakProg, rdPend} = 6'h00;
        {addr, wrData, mismatches, checks_done, cycles} = '0;
        {nExt, nEmpty, nGood} = '0;
        proto = sclc_pkg::PROTO_SDLC;
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        regRead(2'h0, 8'h00, 8'hff);
        regRead(2'h1, 8'h08, 8'hff);
        regRead(2'h3, 8'h00, 8'hff);
        settle();
        checkVal(16'(encoding), 16'(sclc_pkg::ENC_NRZ));
        checkVal(16'(xtalEnable), 16'h0000);
        checkVal(16'(bidirClkOe), 16'h0000);
        // Every receive and transmit source with random pin levels
        for (int i = 0; i < 32; i++)
        begin
            src = 7'($urandom());
            cmc = {i[4], i[3:2], i[1:0], 1'b1, 2'h0};
            i_line.setSrc(src);
            regWrite(2'h0, {1'b0, i[4], 6'h00});
            regWrite(2'h1, cmc);
            settle();
            checkVal(16'(rxClk), 16'(pick(cmc[6:5], cmc[7], 1'b0)));
            checkVal(16'(txClk), 16'(pick(cmc[4:3], cmc[7], i[4])));
            checkVal(16'(bidirClkOe),
                     16'(cmc[6:5] != 2'h1 && cmc[4:3] != 2'h1));
            checkVal(16'(bidirClkOut), 16'(src[6]));
            checkVal(16'(xtalEnable), 16'(cmc[7]));
            checkVal(16'(syncInternal), 16'h0000);
            regRead(2'h1, cmc, 8'hff);
        end
        // Encoding, preset and idle fields
        for (int i = 0; i < 16; i++)
        begin
            regWrite(2'h0, {i[3], i[1:0], 1'b0, i[2], 3'h0});
            settle();
            checkVal(16'(encoding), 16'(i[1:0]));
            checkVal(crcPreset, i[3] ? 16'hffff : 16'h0000);
            checkVal(16'(idleOnes), 16'(i[2]));
            checkVal(16'(crcInvert), 16'h0001);
        end
        i_line.setRes(16'h1d0f);
        i_line.pulse(7);
        i_line.setRes(16'h1d0e);
        i_line.pulse(7);
        settle();
        checkVal(16'(nGood), 16'h0001);
        regWrite(2'h0, 8'hfd);
        @(posedge clk);
        chanReset <= 1'b1;
        @(posedge clk);
        chanReset <= 1'b0;
        regRead(2'h0, 8'h60, 8'hff);
        // Short sync per protocol
        regWrite(2'h0, 8'h01);
        setProto(sclc_pkg::PROTO_MONO);
        settle();
        checkVal(16'({shortSync, bisyncRx12}), 16'h0002);
        setProto(sclc_pkg::PROTO_BI);
        settle();
        checkVal(16'(bisyncRx12), 16'h0001);
        setProto(sclc_pkg::PROTO_SDLC);
        settle();
        checkVal(16'(shortSync), 16'h0000);
        // Underrun closing with each response; host write to TRMC clears underrunEom
        for (int ab = 0; ab < 2; ab++)
        begin
            nExt = 0;
            nEmpty = 0;
            regWrite(2'h0, {4'h0, 1'(ab), 1'(ab), 2'h0});
            i_line.pulse(5);
            settle();
            checkVal(16'(nExt), 16'h0001);
            checkVal(16'(underrunEom), 16'h0001);
            checkVal(16'({sendAbortFlag, sendCrc}), ab ? 16'h2 : 16'h1);
            checkVal(16'(idleOnes), 16'(ab));
            repeat (15) i_line.pulse(6);
            settle();
            checkVal(16'(nEmpty), 16'h0000);
            i_line.pulse(6);
            settle();
            checkVal(16'(nEmpty), 16'h0001);
            regWrite(2'h0, 8'h00);
            settle();
            checkVal(16'(underrunEom), 16'h0000);
        end
        // SDLC loop entry, going on-loop and deferred exit; host order
        regWrite(2'h0, 8'h02);
        for (int k = 0; k < 4; k++)
        begin
            i_line.setLine({k[1], k[0]});
            settle();
            checkVal(16'({txLine, oneBitDelay}), 16'({k[0], 1'b0}));
        end
        regRead(2'h2, 8'h01, 8'h03);
        regWrite(2'h0, 8'h12);
        i_line.pulse(0);
        settle();
        checkVal(16'(oneBitDelay), 16'h0001);
        regRead(2'h2, 8'h03, 8'h03);
        regWrite(2'h0, 8'h00);
        settle();
        regRead(2'h2, 8'h03, 8'h03);
        i_line.pulse(0);
        settle();
        regRead(2'h2, 8'h00, 8'h03);
        // Go active on poll, give way after a flag, wait for flag and poll
        regWrite(2'h0, 8'h12);
        i_line.pulse(0);
        i_line.pulse(0);
        settle();
        checkVal(16'(txActive), 16'h0001);
        regWrite(2'h0, 8'h02);
        i_line.pulse(4);
        settle();
        regRead(2'h2, 8'h13, 8'h1f);
        regWrite(2'h0, 8'h12);
        i_line.pulse(0);
        settle();
        regRead(2'h2, 8'h13, 8'h1f);
        i_line.pulse(1);
        i_line.pulse(0);
        settle();
        regRead(2'h2, 8'h0a, 8'h1f);
        regWrite(2'h0, 8'h00);
        i_line.pulse(4);
        i_line.pulse(0);
        settle();
        regRead(2'h2, 8'h00, 8'h03);
        // Sync loop: transmitter waits for go-active bit and sync
        setProto(sclc_pkg::PROTO_MONO);
        regWrite(2'h0, 8'h02);
        i_line.pulse(2, 3);
        settle();
        checkVal(16'({txActive, txLine}), 16'h0001);
        @(posedge clk);
        breakProg <= 1'b1;
        settle();
        checkVal(16'(txLine), 16'h0000);
        regWrite(2'h0, 8'h12);
        i_line.pulse(2, 3);
        settle();
        checkVal(16'({txActive, txLine}), 16'h0003);
        // Preset and inversion ignored in async mode
        regWrite(2'h0, 8'h80);
        setProto(sclc_pkg::PROTO_ASYNC);
        settle();
        checkVal(crcPreset, 16'h0000);
        checkVal(16'(crcInvert), 16'h0000);
        settle();
        stop_test();
    end
endmodule
`default_nettype wire
